/* scr_pkg.sv */
// shared constants and types for the serial receive/transmit channel block
// assumes an 8-bit host register port and byte-wide receive characters
package scr_pkg;

  localparam logic [7:0] SCR_OFS_TERM_CHAR = 8'h26;
  localparam logic [7:0] SCR_OFS_RX_FIFO_CONTROL = 8'h28;
  localparam logic [7:0] SCR_OFS_COUNT_LOW = 8'h2A;
  localparam logic [7:0] SCR_OFS_COUNT_HIGH = 8'h2B;
  localparam logic [7:0] SCR_OFS_CONFIG_ZERO = 8'h2C;
  localparam logic [7:0] SCR_OFS_CONFIG_ONE = 8'h2D;

  localparam logic [7:0] SCR_RST_CONFIG = 8'h00;
  localparam logic [7:0] SCR_RST_RX_FIFO_CONTROL = 8'h00;
  localparam logic [7:0] SCR_RST_TERM_CHAR = 8'h00;

  // rx_fifo_control fields
  localparam int SCR_RFC_TERM_EN = 0;
  localparam int SCR_RFC_THRESH_LO = 2;
  localparam int SCR_RFC_STATUS_EN = 4;
  localparam int SCR_RFC_FLOW_DISABLE = 5;
  localparam int SCR_RFC_PARITY_DISABLE = 6;

  // tx_block_len_high / rx_count_high fields
  localparam int SCR_XH_DMA = 7;
  localparam int SCR_XH_CAS = 5;
  localparam int SCR_XH_CONT = 4;

  // channel_config_zero fields
  localparam int SCR_C0_POWER = 7;
  localparam int SCR_C0_MCE = 6;
  localparam int SCR_C0_ENC_LO = 2;
  localparam int SCR_C0_MODE_LO = 0;

  // channel_config_one fields
  localparam int SCR_C1_ODS = 4;
  localparam int SCR_C1_BCR = 3;
  localparam int SCR_C1_CM_LO = 0;

  // status byte fields
  localparam int SCR_ST_PE = 7;
  localparam int SCR_ST_FE = 6;
  localparam int SCR_ST_PAR = 0;

  localparam logic [2:0] SCR_CLOCK_MODE_ONE = 3'h1;
  localparam logic [2:0] SCR_CLOCK_MODE_FIVE = 3'h5;

  typedef enum logic [2:0] {
    SCR_ENC_NRZ = 3'h0,
    SCR_ENC_RSV1 = 3'h1,
    SCR_ENC_NRZI = 3'h2,
    SCR_ENC_RSV3 = 3'h3,
    SCR_ENC_FM0 = 3'h4,
    SCR_ENC_FM1 = 3'h5,
    SCR_ENC_MANCH = 3'h6,
    SCR_ENC_UNUSED = 3'h7
  } scr_encoding_t;

  typedef enum logic [1:0] {
    SCR_MODE_HDLC = 2'h0,
    SCR_MODE_LOOP = 2'h1,
    SCR_MODE_BISYNC = 2'h2,
    SCR_MODE_ASYNC = 2'h3
  } scr_protocol_t;

  typedef struct packed {
    logic [7:0] char_bits;
    logic parity;
    logic parity_err;
    logic frame_err;
    logic flow_char;
  } scr_rx_char_t;

  typedef struct packed {
    logic power_active;
    logic master_clock_sel;
    scr_encoding_t line_encoding;
    logic encoding_reserved;
    scr_protocol_t protocol_mode;
    logic oversample_16x;
    logic majority_vote;
    logic output_driver_select;
    logic [2:0] clock_mode_select;
    logic dma_mode;
  } scr_chan_cfg_t;

endpackage

/* scr_channel.sv */
// receive fifo control, transmit block length and channel configuration
// assumes a byte-wide host port synchronous to clk_i and a character
// source that already framed, checked and flagged each received character
`timescale 1ns/1ns
module scr_channel #(
  parameter int COUNT_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic receive_memory_complete_cmd_i,
  input wire logic transmit_frame_cmd_i,
  input wire logic pool_full_int_enable_i,
  input wire logic interrupt_mask_zero_term_i,
  input wire logic parity_enable_i,
  input wire logic [1:0] char_length_i,
  input wire logic carrier_detect_input_i,
  input wire logic rx_valid_i,
  input wire scr_pkg::scr_rx_char_t rx_char_i,
  output logic rx_ready_o,
  output logic fifo_valid_o,
  output logic [7:0] fifo_data_o,
  input wire logic fifo_ready_i,
  output logic receive_pool_full_interrupt_o,
  output logic term_char_interrupt_o,
  output logic dma_req_o,
  input wire logic dma_ack_i,
  output logic rx_enable_o,
  output logic carrier_general_o,
  output scr_pkg::scr_chan_cfg_t cfg_o
);
  import scr_pkg::*;

  logic [7:0] term_char;
  logic [7:0] rx_fifo_control;
  logic [7:0] channel_config_zero;
  logic [7:0] channel_config_one;
  logic [11:0] tx_block_length;
  logic dma_mode, carrier_auto_start, continuous_transmit;
  logic [COUNT_W-1:0] rx_byte_counter;
  logic [5:0] pool_cnt;
  logic term_seen;
  logic [12:0] tx_remaining;
  logic xc_run;
  logic [7:0] buf_mem [2];
  logic [1:0] buf_cnt;
  logic stat_pending;
  logic [7:0] stat_byte;

  logic status_en, flow_disable, term_en, power;
  logic [5:0] thresh;
  logic rx_fire, drop, push, pop, rpf_evt, rmc_clear, term_hit;
  logic [7:0] data_byte, push_byte;
  logic [1:0] next_cnt;
  logic [7:0] next_mem [2];
  logic next_stat;
  logic [12:0] next_rem;
  logic [COUNT_W-1:0] rbc_view;

  // threshold in bytes from code and status format
  function automatic logic [5:0] thresh_bytes(input logic [1:0] code,
                                              input logic st);
    case (code)
      2'h0: thresh_bytes = st ? 6'h02 : 6'h01;
      2'h1: thresh_bytes = 6'h04;
      2'h2: thresh_bytes = 6'h10;
      default: thresh_bytes = 6'h20;
    endcase
  endfunction

  // character bits up to length, parity placed just above when kept
  function automatic logic [7:0] pack_data(input logic [7:0] c,
                                           input logic p,
                                           input logic [1:0] len,
                                           input logic pen,
                                           input logic parity_storage_disable);
    logic [7:0] m;
    logic [7:0] pbit;
    m = 8'hFF >> len;
    pbit = 8'h00;
    if (pen && len != 2'h0 && !parity_storage_disable) begin
      pbit = 8'(p) << (4'h8 - {2'h0, len});
    end
    pack_data = (c & m) | pbit;
  endfunction

  assign status_en = rx_fifo_control[SCR_RFC_STATUS_EN];
  assign flow_disable = rx_fifo_control[SCR_RFC_FLOW_DISABLE];
  assign term_en = rx_fifo_control[SCR_RFC_TERM_EN];
  assign power = channel_config_zero[SCR_C0_POWER];
  assign thresh = thresh_bytes(rx_fifo_control[SCR_RFC_THRESH_LO +: 2],
                               status_en);

  assign rx_fire = rx_valid_i && rx_ready_o;
  assign drop = flow_disable && rx_char_i.flow_char;
  assign data_byte = pack_data(rx_char_i.char_bits, rx_char_i.parity,
                               char_length_i, parity_enable_i,
                               rx_fifo_control[SCR_RFC_PARITY_DISABLE]);
  assign pop = fifo_valid_o && fifo_ready_i;
  assign push = stat_pending ? (buf_cnt != 2'h2 || pop) : (rx_fire && !drop);
  assign push_byte = stat_pending ? stat_byte : data_byte;
  assign term_hit = rx_fire && term_en &&
                    ((rx_char_i.char_bits & (8'hFF >> char_length_i)) ==
                     term_char);
  assign rpf_evt = pop && ({26'h0, pool_cnt} + 32'd1 == {26'h0, thresh});
  assign rmc_clear = receive_memory_complete_cmd_i && term_seen;
  assign rbc_view = rx_byte_counter + COUNT_W'(pool_cnt);

  // two-entry buffer toward the receive fifo; head at index 0
  always_comb begin
    next_mem[0] = buf_mem[0];
    next_mem[1] = buf_mem[1];
    next_cnt = buf_cnt;
    if (pop) begin
      next_mem[0] = buf_mem[1];
      next_cnt = buf_cnt - 2'h1;
    end
    if (push) begin
      next_mem[next_cnt[0]] = push_byte;
      next_cnt = next_cnt + 2'h1;
    end
    next_stat = stat_pending;
    if (stat_pending && push) begin
      next_stat = 1'b0;
    end else if (rx_fire && !drop && status_en) begin
      next_stat = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
      buf_cnt <= 2'h0;
      stat_pending <= 1'b0;
      stat_byte <= 8'h00;
      fifo_valid_o <= 1'b0;
      fifo_data_o <= 8'h00;
      rx_ready_o <= 1'b0;
    end else begin
      buf_mem[0] <= next_mem[0];
      buf_mem[1] <= next_mem[1];
      buf_cnt <= next_cnt;
      stat_pending <= next_stat;
      if (rx_fire) begin
        stat_byte <= 8'h00;
        stat_byte[SCR_ST_PE] <= rx_char_i.parity_err;
        stat_byte[SCR_ST_FE] <= rx_char_i.frame_err;
        stat_byte[SCR_ST_PAR] <= rx_char_i.parity;
      end
      fifo_valid_o <= next_cnt != 2'h0;
      fifo_data_o <= next_mem[0];
      // the whole buffer must be empty so a following status byte fits
      rx_ready_o <= rx_enable_o && !next_stat && next_cnt == 2'h0;
    end
  end

  // pool fill and receive byte counting
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pool_cnt <= 6'h00;
      rx_byte_counter <= '0;
      term_seen <= 1'b0;
      receive_pool_full_interrupt_o <= 1'b0;
      term_char_interrupt_o <= 1'b0;
    end else begin
      if (rpf_evt) begin
        pool_cnt <= 6'h00;
      end else if (pop) begin
        pool_cnt <= pool_cnt + 6'h01;
      end
      // clear first so a same-cycle pool event still counts
      if (rmc_clear && rpf_evt) begin
        rx_byte_counter <= COUNT_W'(thresh);
      end else if (rmc_clear) begin
        rx_byte_counter <= '0;
      end else if (rpf_evt) begin
        rx_byte_counter <= rx_byte_counter + COUNT_W'(thresh);
      end
      if (term_hit) begin
        term_seen <= 1'b1;
      end else if (receive_memory_complete_cmd_i) begin
        term_seen <= 1'b0;
      end
      receive_pool_full_interrupt_o <= rpf_evt && pool_full_int_enable_i;
      term_char_interrupt_o <= term_hit && interrupt_mask_zero_term_i;
    end
  end

  // host register writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      term_char <= SCR_RST_TERM_CHAR;
      rx_fifo_control <= SCR_RST_RX_FIFO_CONTROL;
      channel_config_zero <= SCR_RST_CONFIG;
      channel_config_one <= SCR_RST_CONFIG;
      tx_block_length <= 12'h000;
      dma_mode <= 1'b0;
      carrier_auto_start <= 1'b0;
      continuous_transmit <= 1'b0;
    end else if (wr_en_i) begin
      case (addr_i)
        SCR_OFS_TERM_CHAR: term_char <= wdata_i;
        SCR_OFS_RX_FIFO_CONTROL: rx_fifo_control <= wdata_i & 8'h7D;
        SCR_OFS_COUNT_LOW: tx_block_length[7:0] <= wdata_i;
        SCR_OFS_COUNT_HIGH: begin
          tx_block_length[11:8] <= wdata_i[3:0];
          dma_mode <= wdata_i[SCR_XH_DMA];
          carrier_auto_start <= wdata_i[SCR_XH_CAS];
          continuous_transmit <= wdata_i[SCR_XH_CONT];
        end
        SCR_OFS_CONFIG_ZERO: channel_config_zero <= wdata_i & 8'hDF;
        SCR_OFS_CONFIG_ONE: channel_config_one <= wdata_i & 8'h1F;
        default: ;
      endcase
    end
  end

  // host register reads; unmapped offsets read zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_en_i) begin
      case (addr_i)
        SCR_OFS_TERM_CHAR: rdata_o <= term_char;
        SCR_OFS_RX_FIFO_CONTROL: rdata_o <= rx_fifo_control;
        SCR_OFS_COUNT_LOW: rdata_o <= rbc_view[7:0];
        SCR_OFS_COUNT_HIGH: begin
          rdata_o <= {dma_mode, 1'b0, carrier_auto_start, 1'b0,
                      cfg_o.protocol_mode == SCR_MODE_ASYNC ? 4'h0 :
                      rbc_view[11:8]};
        end
        SCR_OFS_CONFIG_ZERO: rdata_o <= channel_config_zero;
        SCR_OFS_CONFIG_ONE: rdata_o <= channel_config_one;
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  // transmit DMA request run
  always_comb begin
    next_rem = tx_remaining;
    if (dma_req_o && dma_ack_i && tx_remaining != 13'h0000) begin
      next_rem = tx_remaining - 13'h0001;
    end
    if (transmit_frame_cmd_i && dma_mode && power) begin
      next_rem = {1'b0, tx_block_length} + 13'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_remaining <= 13'h0000;
      xc_run <= 1'b0;
      dma_req_o <= 1'b0;
    end else begin
      tx_remaining <= next_rem;
      if (!dma_mode || !continuous_transmit || !power) begin
        xc_run <= 1'b0;
      end else if (transmit_frame_cmd_i) begin
        xc_run <= 1'b1;
      end
      // interrupt mode never asks the DMA controller for data
      dma_req_o <= power && dma_mode &&
                   (xc_run || next_rem != 13'h0000);
    end
  end

  // configuration decode, registered toward the channel logic
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_o <= '0;
      rx_enable_o <= 1'b0;
      carrier_general_o <= 1'b0;
    end else begin
      cfg_o.power_active <= power;
      cfg_o.master_clock_sel <= channel_config_zero[SCR_C0_MCE] &&
        channel_config_one[SCR_C1_CM_LO +: 3] != SCR_CLOCK_MODE_FIVE;
      cfg_o.line_encoding <=
        scr_encoding_t'(channel_config_zero[SCR_C0_ENC_LO +: 3]);
      cfg_o.encoding_reserved <=
        channel_config_zero[SCR_C0_ENC_LO +: 3] == SCR_ENC_RSV1 ||
        channel_config_zero[SCR_C0_ENC_LO +: 3] == SCR_ENC_RSV3 ||
        channel_config_zero[SCR_C0_ENC_LO +: 3] == SCR_ENC_UNUSED;
      cfg_o.protocol_mode <=
        scr_protocol_t'(channel_config_zero[SCR_C0_MODE_LO +: 2]);
      cfg_o.oversample_16x <= channel_config_one[SCR_C1_BCR];
      // majority vote only meaningful on NRZ; other encodings sample once
      cfg_o.majority_vote <= channel_config_one[SCR_C1_BCR] &&
        channel_config_zero[SCR_C0_ENC_LO +: 3] == SCR_ENC_NRZ;
      cfg_o.output_driver_select <= channel_config_one[SCR_C1_ODS];
      cfg_o.clock_mode_select <= channel_config_one[SCR_C1_CM_LO +: 3];
      cfg_o.dma_mode <= dma_mode;
      rx_enable_o <= power &&
                     (!carrier_auto_start || carrier_detect_input_i);
      carrier_general_o <= !carrier_auto_start && carrier_detect_input_i &&
        channel_config_one[SCR_C1_CM_LO +: 3] != SCR_CLOCK_MODE_ONE &&
        channel_config_one[SCR_C1_CM_LO +: 3] != SCR_CLOCK_MODE_FIVE;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_char_kept;
    rx_fire && !drop && status_en;
  endsequence
  sequence s_status_out;
    stat_pending ##[0:4] (stat_pending && push) ##1 !stat_pending;
  endsequence

  a_flow_char_drop: assert property (
    (rx_fire && drop && !stat_pending) |-> !push)
    else $error("suppressed flow character was stored");
  a_status_byte_follows: assert property (
    s_char_kept |=> s_status_out)
    else $error("status byte did not follow data byte");
  a_threshold_code: assert property (
    (rx_fifo_control[3:2] == 2'h0 && status_en) |-> thresh == 6'h02)
    else $error("threshold code 00 with status is not 2");
  a_pool_full_irq: assert property (
    (rpf_evt && pool_full_int_enable_i) |=> receive_pool_full_interrupt_o)
    else $error("pool full interrupt missing");
  a_term_char_irq: assert property (
    (term_hit && interrupt_mask_zero_term_i) |=> term_char_interrupt_o)
    else $error("termination interrupt missing");
  a_count_clear: assert property (
    (rmc_clear && !rpf_evt) |=> rx_byte_counter == '0)
    else $error("byte counter not cleared");
  a_count_add: assert property (
    (rpf_evt && !rmc_clear) |=>
      rx_byte_counter == $past(rx_byte_counter) + COUNT_W'($past(thresh)))
    else $error("byte counter not advanced by threshold");
  a_block_length: assert property (
    (transmit_frame_cmd_i && dma_mode && power) |=>
      tx_remaining == {1'b0, $past(tx_block_length)} + 13'h0001)
    else $error("block length is not count plus one");
  a_dma_stop: assert property (
    (tx_remaining == 13'h0000 && !xc_run && !transmit_frame_cmd_i)
      |=> !dma_req_o)
    else $error("DMA request beyond block length");
  a_standby_rx: assert property (
    !power |=> !rx_enable_o ##1 !rx_ready_o)
    else $error("receiver active in standby");
  a_master_clock: assert property (
    (channel_config_one[2:0] == SCR_CLOCK_MODE_FIVE) |=>
      !cfg_o.master_clock_sel)
    else $error("master clock selected in clock mode 5");
endmodule

/* scr_line_partner.sv */
// serial line partner: hands framed, checked characters to the channel
// assumes rx_ready_i comes from a flop, so it is stable between edges
`timescale 1ns/1ns
module scr_line_partner (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output scr_pkg::scr_rx_char_t rx_char_o
);
  import scr_pkg::*;
  logic r;
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o = '0;
    r = 1'b0;
  end
  // holds the character until ready is seen high at an edge, giving up after 40 cycles
  task automatic send(input scr_rx_char_t c, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_char_o <= c;
    for (n = 0; n < 40 && !ok; n++) begin
      @(negedge clk_i);
      r = rx_ready_i;
      @(posedge clk_i);
      ok = r && rst_n_i;
    end
    rx_valid_o <= 1'b0;
    // the line has moved on: never leave the old character showing
    rx_char_o <= ~c;
  endtask
endmodule

/* scr_channel_tb.sv */
// self-checking bench for scr_channel: registers, receive path, dma
// assumes scr_pkg is compiled first and scr_line_partner feeds characters
`timescale 1ns/1ns
module scr_channel_tb;
  import scr_pkg::*;
  logic clk_i, rst_n_i, wr_en, rd_en, receive_memory_complete_cmd, xf, pf_en, tc_en, par_en, cd;
  logic rx_valid, rx_ready, fvalid, fready, pf, tc, dreq, dack, rx_en;
  logic cd_gen;
  logic [1:0] chl, st;
  logic [7:0] addr, wdata, rdata, fdata, rv;
  scr_rx_char_t rx_char;
  scr_chan_cfg_t cfg;
  int n_fail, compares, n_pf, n_tc, n_ack, k;
  logic [7:0] got[$];
  logic [7:0] ofs[5] = '{8'h2C, 8'h2D, 8'h28, 8'h26, 8'h10};
  logic [7:0] msk[3] = '{8'hDF, 8'h1F, 8'h7D};
  logic [7:0] exp6[6] = '{8'hA5, 8'h81, 8'h3C, 8'h40, 8'h5A, 8'h00};

  scr_channel scr_channel_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr), .wr_en_i(wr_en), .rd_en_i(rd_en), .wdata_i(wdata),
    .rdata_o(rdata), .receive_memory_complete_cmd_i(receive_memory_complete_cmd),
    .transmit_frame_cmd_i(xf), .pool_full_int_enable_i(pf_en),
    .interrupt_mask_zero_term_i(tc_en), .parity_enable_i(par_en),
    .char_length_i(chl), .carrier_detect_input_i(cd),
    .rx_valid_i(rx_valid), .rx_char_i(rx_char), .rx_ready_o(rx_ready),
    .fifo_valid_o(fvalid), .fifo_data_o(fdata), .fifo_ready_i(fready),
    .receive_pool_full_interrupt_o(pf), .term_char_interrupt_o(tc),
    .dma_req_o(dreq), .dma_ack_i(dack), .rx_enable_o(rx_en),
    .carrier_general_o(cd_gen), .cfg_o(cfg));
  scr_line_partner scr_line_partner_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_char_o(rx_char));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // the fifo side stalls three cycles of four to exercise the buffer
  always @(posedge clk_i) begin
    if (pf) n_pf++;
    if (tc) n_tc++;
    if (dreq && dack) n_ack++;
    if (fvalid && fready) got.push_back(fdata);
    st <= st + 2'h1;
    fready <= (st == 2'h3);
  end

  task automatic results();
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr_en <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk_i);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd_en <= 1'b0;
    @(posedge clk_i);
    #1 rv = rdata;
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic cmd(logic frame);
    @(posedge clk_i);
    if (frame) xf <= 1'b1;
    else receive_memory_complete_cmd <= 1'b1;
    @(posedge clk_i);
    xf <= 1'b0;
    receive_memory_complete_cmd <= 1'b0;
  endtask
  task automatic tx(scr_rx_char_t c);
    logic ok;
    scr_line_partner_i.send(c, ok);
    if (!ok) begin
      n_fail++;
      results();
    end
  endtask

  initial begin
    {wr_en, rd_en, receive_memory_complete_cmd, xf, dack, cd, fready, par_en} = '0;
    {pf_en, tc_en} = 2'b11;
    {addr, wdata, chl, st} = '0;
    {n_fail, compares, n_pf, n_tc, n_ack} = '0;
    rst_n_i = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle(1);
    chk("rx_ready", 8'h00, {7'h00, rx_ready});
    for (k = 0; k < 5; k++) begin
      rd(ofs[k]);
      chk("reset value", 8'h00, rv);
    end
    for (k = 0; k < 3; k++) begin
      wr(ofs[k], 8'hFF);
      rd(ofs[k]);
      chk("write mask", msk[k], rv);
    end
    for (k = 0; k < 8; k++) begin
      wr(SCR_OFS_CONFIG_ZERO, {3'b110, k[2:0], k[1:0]});
      wr(SCR_OFS_CONFIG_ONE, {5'h00, k[2:0]});
      settle(2);
      chk("encoding", {5'h00, k[2:0]}, {5'h00, cfg.line_encoding});
      chk("protocol", {6'h00, k[1:0]}, {6'h00, cfg.protocol_mode});
      chk("clock mode", {5'h00, k[2:0]}, 8'(cfg.clock_mode_select));
      rv = {7'h00, k == 1 || k == 3 || k == 7};
      chk("reserved code", rv, {7'h00, cfg.encoding_reserved});
      rv = {7'h00, k != 5};
      chk("master clock", rv, {7'h00, cfg.master_clock_sel});
    end
    wr(SCR_OFS_CONFIG_ZERO, 8'hC3);
    wr(SCR_OFS_CONFIG_ONE, 8'h08);
    settle(3);
    chk("cfg bits", 8'h0F, {4'h0, cfg.power_active, cfg.master_clock_sel,
      cfg.oversample_16x, cfg.majority_vote});
    chk("rx_ready", 8'h01, {7'h00, rx_ready});
    wr(SCR_OFS_COUNT_HIGH, 8'hAF);
    rd(SCR_OFS_COUNT_HIGH);
    chk("count high", 8'hA0, rv);
    chk("dma mode", 8'h01, {7'h00, cfg.dma_mode});
    chk("auto start idle", 8'h00, {7'h00, rx_en});
    @(posedge clk_i);
    cd <= 1'b1;
    settle(3);
    chk("auto start", 8'h01, {7'h00, rx_en});
    chk("carrier in use", 8'h00, {7'h00, cd_gen});
    wr(SCR_OFS_COUNT_HIGH, 8'h00);
    settle(3);
    chk("carrier general", 8'h01, {7'h00, cd_gen});
    wr(SCR_OFS_COUNT_LOW, 8'h02);
    wr(SCR_OFS_COUNT_HIGH, 8'h80);
    dack <= 1'b1;
    settle(1);
    n_ack = 0;
    cmd(1'b1);
    settle(12);
    chk("dma acks", 8'h03, n_ack[7:0]);
    chk("dma req", 8'h00, {7'h00, dreq});
    wr(SCR_OFS_COUNT_HIGH, 8'h90);
    cmd(1'b1);
    settle(20);
    chk("continuous req", 8'h01, {7'h00, dreq});
    wr(SCR_OFS_COUNT_HIGH, 8'h00);
    settle(3);
    n_ack = 0;
    cmd(1'b1);
    settle(6);
    chk("interrupt mode acks", 8'h00, n_ack[7:0]);
    wr(SCR_OFS_TERM_CHAR, 8'h5A);
    wr(SCR_OFS_RX_FIFO_CONTROL, 8'h15);
    settle(4);
    got.delete();
    n_pf = 0;
    n_tc = 0;
    tx({8'hA5, 4'hC});
    tx({8'h3C, 4'h2});
    tx({8'h5A, 4'h0});
    settle(20);
    for (k = 0; k < 6; k++)
      chk("fifo byte", exp6[k], got[k]);
    chk("pool full", 8'h01, n_pf[7:0]);
    chk("term int", 8'h01, n_tc[7:0]);
    rd(SCR_OFS_COUNT_LOW);
    chk("rx count", 8'h06, rv);
    chk("valid bytes", 8'h02, rv & 8'h03);
    cmd(1'b0);
    settle(2);
    rd(SCR_OFS_COUNT_LOW);
    chk("rx count cleared", 8'h02, rv);
    @(posedge clk_i);
    tc_en <= 1'b0;
    tx({8'h5A, 4'h0});
    settle(10);
    chk("masked term", 8'h01, n_tc[7:0]);
    cmd(1'b0);
    wr(SCR_OFS_RX_FIFO_CONTROL, 8'h20);
    settle(2);
    got.delete();
    n_pf = 0;
    tx({8'h11, 4'h1});
    tx({8'h22, 4'h0});
    settle(12);
    chk("flow dropped", 8'h22, got[0]);
    chk("one byte pool", 8'h01, n_pf[7:0]);
    wr(SCR_OFS_RX_FIFO_CONTROL, 8'h00);
    chl <= 2'h1;
    par_en <= 1'b1;
    tx({8'h11, 4'h1});
    tx({8'h41, 4'h8});
    wr(SCR_OFS_RX_FIFO_CONTROL, 8'h40);
    tx({8'h41, 4'h8});
    settle(12);
    chk("flow stored", 8'h11, got[1]);
    chk("parity kept", 8'hC1, got[2]);
    chk("parity dropped", 8'h41, got[3]);
    rv = 8'(got.size());
    chk("byte total", 8'h04, rv);
    results();
  end
endmodule
